// *** hw/pspm_pkg.sv ***
// Constants, field layouts and helpers of the stream performance monitor
`default_nettype none
package pspm_pkg;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam longint CLK_PERIOD_NS = 40;
  localparam longint ONE_SEC_NS = 1000000000;
  localparam int SEC_CYCLES = int'(ONE_SEC_NS / CLK_PERIOD_NS);

  // ----------------------------------------------------------------------
  // Widths, keep patterns, reset values
  // ----------------------------------------------------------------------
  localparam int DATA_W = 64;
  localparam int KEEP_W = 8;
  localparam int CNT_W = 32;
  localparam int IDX_W = 2;
  localparam logic [7:0] KEEP_ALL = 8'hFF;
  localparam logic [7:0] KEEP_LOW = 8'h0F;
  localparam logic [3:0] BYTES_FULL = 4'h8;
  localparam logic [3:0] BYTES_HALF = 4'h4;
  localparam logic [31:0] CNT_RST = 32'h0;
  localparam logic [1:0] IDX_RST = 2'h0;
  localparam int DSC_BIT = 3;

  // ----------------------------------------------------------------------
  // Header word 0 of a packet sits in data[31:0]
  // ----------------------------------------------------------------------
  localparam int FMT_DATA_BIT = 30;
  localparam int TYPE_HI = 28;
  localparam int TYPE_LO = 24;
  localparam logic [4:0] TYPE_MEM = 5'h00;
  localparam logic [4:0] TYPE_CPL = 5'h0A;

  function automatic logic [3:0] pspm_beat_bytes(input logic last,
                                                  input logic [7:0] keep);
    pspm_beat_bytes = (last && keep == KEEP_LOW) ? BYTES_HALF : BYTES_FULL;
  endfunction : pspm_beat_bytes

  function automatic logic pspm_is_payload(input logic [31:0] dw0);
    logic [4:0] kind;
    kind = dw0[TYPE_HI:TYPE_LO];
    pspm_is_payload = dw0[FMT_DATA_BIT] && (kind == TYPE_MEM ||
                                            kind == TYPE_CPL);
  endfunction : pspm_is_payload

endpackage : pspm_pkg
`default_nettype wire

// *** hw/pspm_lane_if.sv ***
// Observed stream and accumulators of one direction
`timescale 1ns/1ns
`default_nettype none
interface pspm_lane_if;
  logic [63:0] data;
  logic [7:0] keep;
  logic last;
  logic valid;
  logic ready;
  logic dsc;
  logic tick;
  logic [31:0] byte_acc;
  logic [31:0] pay_acc;
  modport lane (input data, keep, last, valid, ready, dsc, tick,
                output byte_acc, pay_acc);
  modport top (output data, keep, last, valid, ready, dsc, tick,
               input byte_acc, pay_acc);
endinterface : pspm_lane_if
`default_nettype wire

// *** hw/pspm_lane.sv ***
// Per-direction beat and payload accumulator
`timescale 1ns/1ns
`default_nettype none
module pspm_lane (
  input wire logic clock,
  input wire logic resetn,
  pspm_lane_if.lane s
);

  // ----------------------------------------------------------------------
  // Beat qualification
  // ----------------------------------------------------------------------
  logic sop_q, sop_d;
  logic in_pay_q, in_pay_d;
  logic [31:0] byte_q, byte_d, pay_q, pay_d;
  wire fire = s.valid && s.ready;
  wire eof = fire && (s.last || s.dsc);
  wire [3:0] bytes = pspm_pkg::pspm_beat_bytes(s.last, s.keep);
  wire head_pay = pspm_pkg::pspm_is_payload(s.data[31:0]);
  wire beat_pay = (sop_q ? head_pay : in_pay_q);
  wire [31:0] add_b = fire ? 32'(bytes) : 32'h0;
  wire [31:0] add_p = (fire && beat_pay) ? 32'(bytes) : 32'h0;

  // Frame start follows an end-of-frame beat; header is only read then
  assign sop_d = fire ? eof : sop_q;
  assign in_pay_d = (fire && sop_q) ? head_pay : in_pay_q;
  // Beats landing on the tick open the next interval, none are lost
  assign byte_d = s.tick ? add_b : byte_q + add_b;
  assign pay_d = s.tick ? add_p : pay_q + add_p;
  assign s.byte_acc = byte_q;
  assign s.pay_acc = pay_q;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sop_q <= 1'b1;
      in_pay_q <= 1'b0;
      byte_q <= pspm_pkg::CNT_RST;
      pay_q <= pspm_pkg::CNT_RST;
    end else begin
      sop_q <= sop_d;
      in_pay_q <= in_pay_d;
      byte_q <= byte_d;
      pay_q <= pay_d;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  idle_hold_a: assert property (!s.tick && !fire |=> $stable(byte_q))
    else $error("byte count moved without an accepted beat");
  half_beat_a: assert property (!s.tick && fire && s.last &&
      s.keep == pspm_pkg::KEEP_LOW |=> byte_q == $past(byte_q) + 32'h4)
    else $error("final half beat not counted as four bytes");
  full_beat_a: assert property (!s.tick && fire && !s.last
      |=> byte_q == $past(byte_q) + 32'h8)
    else $error("non-final beat not counted as eight bytes");
  frame_start_a: assert property (eof |=> sop_q)
    else $error("no frame start after end of frame");
  payload_bound_a: assert property (pay_q <= byte_q)
    else $error("payload count exceeds raw count");
  tick_clear_a: assert property (s.tick && !fire |=> byte_q == 32'h0)
    else $error("accumulator not restarted on interval end");

endmodule : pspm_lane
`default_nettype wire

// *** hw/pspm_monitor.sv ***
// Top of the passive stream performance monitor
`timescale 1ns/1ns
`default_nettype none
module pspm_monitor #(
  parameter int SEC_CYCLES = pspm_pkg::SEC_CYCLES
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [63:0] tx_data,
  input wire logic [7:0] tx_keep,
  input wire logic tx_last,
  input wire logic tx_valid,
  input wire logic [3:0] tx_user,
  input wire logic tx_ready,
  input wire logic [63:0] rx_data,
  input wire logic [7:0] rx_keep,
  input wire logic rx_last,
  input wire logic rx_valid,
  input wire logic rx_ready,
  output logic [31:0] tx_byte_count,
  output logic [31:0] rx_byte_count,
  output logic [31:0] tx_payload_count,
  output logic [31:0] rx_payload_count
);

  // ----------------------------------------------------------------------
  // One-second timer
  // ----------------------------------------------------------------------
  localparam logic [31:0] LAST_CYCLE = 32'(SEC_CYCLES - 1);
  logic [31:0] timer_q, timer_d;
  wire tick = (timer_q == LAST_CYCLE);
  assign timer_d = tick ? 32'h0 : timer_q + 32'h1;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      timer_q <= pspm_pkg::CNT_RST;
    end else begin
      timer_q <= timer_d;
    end
  end

  // ----------------------------------------------------------------------
  // Observation lanes; every stream signal is an input only
  // ----------------------------------------------------------------------
  pspm_lane_if tx_if ();
  pspm_lane_if rx_if ();

  assign tx_if.data = tx_data;
  assign tx_if.keep = tx_keep;
  assign tx_if.last = tx_last;
  assign tx_if.valid = tx_valid;
  assign tx_if.ready = tx_ready;
  assign tx_if.dsc = tx_user[pspm_pkg::DSC_BIT];
  assign tx_if.tick = tick;
  assign rx_if.data = rx_data;
  assign rx_if.keep = rx_keep;
  assign rx_if.last = rx_last;
  assign rx_if.valid = rx_valid;
  assign rx_if.ready = rx_ready;
  assign rx_if.dsc = 1'b0;
  assign rx_if.tick = tick;

  pspm_lane u_tx_lane (
    .clock(clock),
    .resetn(resetn),
    .s(tx_if.lane)
  );

  pspm_lane u_rx_lane (
    .clock(clock),
    .resetn(resetn),
    .s(rx_if.lane)
  );

  // ----------------------------------------------------------------------
  // Snapshot publication
  // ----------------------------------------------------------------------
  // Software reads each word separately; the index lets it spot a reread
  // of the same interval, at the price of the two lowest count bits.
  logic [1:0] idx_q, idx_d;
  logic [31:0] txb_d, rxb_d, txp_d, rxp_d;
  assign idx_d = tick ? idx_q + 2'h1 : idx_q;
  assign txb_d = tick ? {tx_if.byte_acc[31:2], idx_d} : tx_byte_count;
  assign rxb_d = tick ? {rx_if.byte_acc[31:2], idx_d} : rx_byte_count;
  assign txp_d = tick ? {tx_if.pay_acc[31:2], idx_d} : tx_payload_count;
  assign rxp_d = tick ? {rx_if.pay_acc[31:2], idx_d} : rx_payload_count;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      idx_q <= pspm_pkg::IDX_RST;
      tx_byte_count <= pspm_pkg::CNT_RST;
      rx_byte_count <= pspm_pkg::CNT_RST;
      tx_payload_count <= pspm_pkg::CNT_RST;
      rx_payload_count <= pspm_pkg::CNT_RST;
    end else begin
      idx_q <= idx_d;
      tx_byte_count <= txb_d;
      rx_byte_count <= rxb_d;
      tx_payload_count <= txp_d;
      rx_payload_count <= rxp_d;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  sequence interval_end_s;
    tick;
  endsequence

  sequence published_s;
    ##1 tx_byte_count[1:0] == idx_q && rx_payload_count[1:0] == idx_q;
  endsequence

  timer_wrap_a: assert property (interval_end_s |=> timer_q == 32'h0)
    else $error("timer did not restart after one second");
  timer_step_a: assert property (!tick |=> timer_q == $past(timer_q) + 32'h1)
    else $error("timer skipped a clock");
  index_step_a: assert property (interval_end_s
      |=> idx_q == $past(idx_q) + 2'h1)
    else $error("sample index did not step");
  index_tag_a: assert property (interval_end_s |-> published_s)
    else $error("published low bits differ from sample index");
  publish_raw_a: assert property (interval_end_s
      |=> tx_byte_count[31:2] == $past(tx_if.byte_acc[31:2]))
    else $error("raw transmit count not loaded at interval end");
  publish_pay_a: assert property (interval_end_s
      |=> rx_payload_count[31:2] == $past(rx_if.pay_acc[31:2]))
    else $error("receive payload count not loaded at interval end");
  snap_hold_a: assert property (!tick |=> $stable(rx_byte_count))
    else $error("snapshot changed inside an interval");
  // Own disable so the default reset gating cannot mask this check
  reset_zero_a: assert property (@(posedge clock) disable iff (1'b0)
      !resetn |-> tx_byte_count == 32'h0 && idx_q == 2'h0 &&
      timer_q == 32'h0)
    else $error("state not cleared under reset");

endmodule : pspm_monitor
`default_nettype wire

// *** bench/pspm_stream_src.sv ***
// Behavioural stream source plus its sink's ready, for one direction
`timescale 1ns/1ns
`default_nettype none
module pspm_stream_src (
  input wire logic clock,
  input wire logic go,
  input wire logic [31:0] hdr,
  input wire logic [3:0] beats,
  input wire logic [7:0] mid_keep,
  input wire logic [7:0] end_keep,
  input wire logic end_dsc,
  input wire logic slow,
  output logic [63:0] data,
  output logic [7:0] keep,
  output logic last,
  output logic valid,
  output logic [3:0] user,
  output logic ready,
  output logic busy
);
  int left = 0;
  logic ph = 1'b0;
  logic tk;
  logic first = 1'b0;
  initial begin
    {data, keep, last, valid, user, ready, busy} = '0;
  end
  always @(negedge clock) begin
    tk = valid && ready;
    if (tk) left = left - 1;
    if (go && left == 0) begin
      left = beats;
      first = 1'b1;
    end
    ph = ~ph;
    ready = !slow || ph;
    // A beat once offered is held until the sink takes it
    if (!valid || tk) begin
      if (left > 0 && !(slow && ph)) begin
        valid = 1'b1;
        data = first ? {~hdr, hdr} : {hdr, ~hdr};
        first = 1'b0;
        last = (left == 1);
        user = {end_dsc && left == 1, 3'h0};
        keep = (left == 1) ? end_keep : mid_keep;
      end else begin
        // Idle data and keep lines keep moving, last and user[3] stay high, so a stale value never looks real
        valid = 1'b0;
        data = ~data;
        keep = ~keep;
        last = 1'b1;
        user = 4'h8;
      end
    end
    busy = valid || left > 0;
  end
endmodule : pspm_stream_src
`default_nettype wire

// *** bench/pcie_stream_perf_monitor_tb.sv ***
// Self-checking bench of the stream performance monitor
`timescale 1ns/1ns
`default_nettype none
module pcie_stream_perf_monitor_tb;
  // ------------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------------
  // Short interval keeps the run small; snapshot waits and the time limit follow SEC
  localparam int SEC = 64;
  logic clock = 1'b0;
  logic resetn;
  logic go_t = 1'b0, go_r = 1'b0, dsc_t = 1'b0, slow = 1'b0;
  logic [31:0] hdr_t = 32'h0, hdr_r = 32'h0;
  logic [3:0] nb_t = 4'h1, nb_r = 4'h1, tx_user;
  logic [7:0] mk_r = 8'hFF, ek_t = 8'hFF, ek_r = 8'hFF, tx_keep, rx_keep;
  logic [63:0] tx_data, rx_data;
  logic tx_last, tx_valid, tx_ready, rx_last, rx_valid, rx_ready;
  logic busy_t, busy_r;
  logic [3:0] rx_user;
  logic [31:0] tx_byte_count, rx_byte_count;
  logic [31:0] tx_payload_count, rx_payload_count;
  logic [1:0] idx = 2'h0;
  int n_fail = 0, cmp_count = 0;

  always #20 clock = ~clock;

  pspm_monitor #(.SEC_CYCLES(SEC)) pspm_monitor_inst (
    .clock(clock), .resetn(resetn),
    .tx_data(tx_data), .tx_keep(tx_keep), .tx_last(tx_last),
    .tx_valid(tx_valid), .tx_user(tx_user), .tx_ready(tx_ready),
    .rx_data(rx_data), .rx_keep(rx_keep), .rx_last(rx_last),
    .rx_valid(rx_valid), .rx_ready(rx_ready),
    .tx_byte_count(tx_byte_count), .rx_byte_count(rx_byte_count),
    .tx_payload_count(tx_payload_count),
    .rx_payload_count(rx_payload_count));
  pspm_stream_src pspm_stream_src_inst (
    .clock(clock), .go(go_t), .hdr(hdr_t), .beats(nb_t),
    .mid_keep(8'hFF), .end_keep(ek_t), .end_dsc(dsc_t), .slow(slow),
    .data(tx_data), .keep(tx_keep), .last(tx_last), .valid(tx_valid),
    .user(tx_user), .ready(tx_ready), .busy(busy_t));
  pspm_stream_src pspm_stream_src_inst_rx (
    .clock(clock), .go(go_r), .hdr(hdr_r), .beats(nb_r),
    .mid_keep(mk_r), .end_keep(ek_r), .end_dsc(1'b0), .slow(slow),
    .data(rx_data), .keep(rx_keep), .last(rx_last), .valid(rx_valid),
    .user(rx_user), .ready(rx_ready), .busy(busy_r));

  // ------------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------------
  function automatic logic [31:0] snap(input int b);
    logic [31:0] v;
    v = b;
    return {v[31:2], idx};
  endfunction : snap

  task automatic chk(input int tb, tp, rb, rp);
    if ({tx_byte_count, tx_payload_count, rx_byte_count, rx_payload_count}
        !== {snap(tb), snap(tp), snap(rb), snap(rp)}) begin
      n_fail++;
      $display("FAIL %0t counts %h %h %h %h", $time, tx_byte_count,
               tx_payload_count, rx_byte_count, rx_payload_count);
    end
    cmp_count++;
  endtask : chk

  task automatic send(input logic t, r);
    int k;
    @(negedge clock);
    go_t <= t;
    go_r <= r;
    @(negedge clock);
    go_t <= 1'b0;
    go_r <= 1'b0;
    for (k = 0; k < 40; k++) begin
      @(posedge clock);
      if (!busy_t && !busy_r) break;
    end
  endtask : send

  task automatic next_snap;
    int k;
    idx = idx + 2'h1;
    for (k = 0; k < 3 * SEC && tx_byte_count[1:0] !== idx; k++)
      @(negedge clock);
  endtask : next_snap

  task automatic complete_run;
    if (n_fail == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : complete_run

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_reset;
    chk(0, 0, 0, 0);
    resetn <= 1'b1;
    repeat (4) @(negedge clock);
    chk(0, 0, 0, 0);
    next_snap;
    chk(0, 0, 0, 0);
  endtask : t_reset

  task automatic t_mixed;
    slow <= 1'b1;
    hdr_t <= 32'h4000_0001;
    nb_t <= 4'h3;
    ek_t <= 8'h0F;
    mk_r <= 8'h3C;
    nb_r <= 4'h2;
    send(1'b1, 1'b1);
    next_snap;
    chk(20, 20, 16, 0);
  endtask : t_mixed

  task automatic t_discont;
    slow <= 1'b0;
    hdr_t <= 32'h4A00_0000;
    nb_t <= 4'h2;
    ek_t <= 8'hFF;
    dsc_t <= 1'b1;
    hdr_r <= 32'h4000_0000;
    nb_r <= 4'h4;
    mk_r <= 8'h81;
    ek_r <= 8'h0F;
    send(1'b1, 1'b1);
    dsc_t <= 1'b0;
    hdr_t <= 32'h4400_0000;
    nb_t <= 4'h1;
    ek_t <= 8'h0F;
    send(1'b1, 1'b0);
    next_snap;
    chk(20, 16, 28, 28);
  endtask : t_discont

  task automatic t_wrap_reset;
    next_snap;
    chk(0, 0, 0, 0);
    send(1'b1, 1'b1);
    @(negedge clock);
    resetn <= 1'b0;
    @(negedge clock);
    idx = 2'h0;
    chk(0, 0, 0, 0);
    resetn <= 1'b1;
    next_snap;
    chk(0, 0, 0, 0);
  endtask : t_wrap_reset

  initial begin
    // A real falling edge at time zero clears the design before any clock
    resetn <= 1'b0;
    repeat (8) @(negedge clock);
    t_reset();
    t_mixed();
    t_discont();
    t_wrap_reset();
    complete_run();
  end

  initial begin
    #(40 * SEC * 12);
    n_fail++;
    complete_run();
  end
endmodule : pcie_stream_perf_monitor_tb
`default_nettype wire
